/* File: dv/ssecd_host.sv */
// Host model on the serial link: sends command bytes and reads reply bytes
`timescale 1ns/1ps
module ssecd_host (
  // Serial pins
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  initial begin
    sck = 1'b0;
    si  = 1'b0;
  end

  // Link clock stands still between bytes; the gap leaves the decoder time to load a reply
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    int k;
    #7.3;
    for (k = 7; k >= 0; k--) begin
      si = tx[k];
      #15;
      rx[k] = so;
      sck = 1'b1;
      #15;
      sck = 1'b0;
    end
    // Released data line shows the inverse so a stale level is never mistaken for data
    si = ~tx[0];
    #100;
  endtask

  task automatic send(input logic [7:0] b);
    logic [7:0] d;
    xfer(b, d);
  endtask

  task automatic read(output logic [7:0] r);
    xfer(ssecd_pkg::READ_FILL, r);
  endtask
endmodule // ssecd_host

/* File: dv/ssecd_top_test.sv */
// Self-checking bench for the status and error command decoder
`timescale 1ns/1ps
module ssecd_top_test;
  logic        clk_sys;
  logic        rst_n;
  logic        sck;
  logic        si;
  logic        so;
  logic        so_oe;
  logic [3:0]  accept;
  logic [3:0]  active_n;
  logic [4:0]  flt;
  logic        wdt_ovf;
  logic        rec_ovf;
  logic [7:0]  rom_info;
  logic [7:0]  detect_en;
  logic [7:0]  fault;
  logic        preset_stb;
  logic        play_stb;
  logic [1:0]  ph_chan;
  logic [11:0] ph_num;
  logic        out_a;
  logic        out_b;
  int          n_errors;
  int          tests_run;
  int          n_play;
  int          n_preset;
  logic [13:0] cap;
  logic [7:0]  rd;
  int          i;
  int          fpos [5] = '{ssecd_pkg::FB_HEAT, ssecd_pkg::FB_SHORT, ssecd_pkg::FB_FLASH,
                            ssecd_pkg::FB_OPEN, ssecd_pkg::FB_CLK_STOP};

  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  ssecd_top #(.CH_N(4)) ssecd_top_inst (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .SCK(sck), .SI(si), .SO(so), .SO_OE(so_oe),
    .CMD_ACCEPT_FLAG(accept), .CHANNEL_ACTIVE_N(active_n),
    .CLOCK_STOP_IN(flt[4]), .FLASH_ERR_IN(flt[2]), .OUTPUT_SHORT_IN(flt[1]),
    .OVERHEAT_IN(flt[0]), .SPEAKER_OPEN_IN(flt[3]),
    .WDT_OVERFLOW(wdt_ovf), .RECOVERY_OVERFLOW(rec_ovf), .ROM_INFO(rom_info),
    .DETECT_EN(detect_en), .FAULT_STATUS(fault), .PRESET_STB(preset_stb),
    .PLAY_STB(play_stb), .PHRASE_CHAN(ph_chan), .PHRASE_NUM(ph_num),
    .STATE_OUT_A(out_a), .STATE_OUT_B(out_b)
  );

  ssecd_host ssecd_host_inst (.sck(sck), .si(si), .so(so));

  // Strobes last one cycle, so they are caught at the edge that samples them
  always @(posedge clk_sys) begin
    if (play_stb === 1'b1) begin
      n_play++;
      cap = {ph_chan, ph_num};
    end
    if (preset_stb === 1'b1) begin
      n_preset++;
      cap = {ph_chan, ph_num};
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input int n, input logic [23:0] b);
    int k;
    for (k = n - 1; k >= 0; k--) ssecd_host_inst.send(b[8*k +: 8]);
  endtask

  task automatic rd_err(input logic [7:0] op, output logic [7:0] r);
    ssecd_host_inst.send(op);
    ssecd_host_inst.read(r);
    if (r === 8'h00 && (out_a === 1'b1 || out_b === 1'b1)) begin
      ssecd_host_inst.send(op);
      ssecd_host_inst.read(r);
    end
  endtask

  task automatic pulse(input logic w);
    @(posedge clk_sys);
    wdt_ovf <= w;
    rec_ovf <= ~w;
    @(posedge clk_sys);
    wdt_ovf <= 1'b0;
    rec_ovf <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic final_report;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    accept = 4'hD;
    active_n = 4'hE;
    flt = 5'h00;
    wdt_ovf = 1'b0;
    rec_ovf = 1'b0;
    rom_info = 8'hA5;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk(16'(detect_en), 16'h0000);
    chk(16'(fault), 16'h0000);
    chk(16'(out_a), 16'(accept[0]));
    chk(16'(out_b), 16'(active_n[0]));
    // No channel ready: these commands must still be served
    @(posedge clk_sys) accept <= 4'h0;
    ssecd_host_inst.send(ssecd_pkg::OP_ROM_INFO);
    ssecd_host_inst.read(rd);
    chk(16'(rd), 16'(rom_info));
    chk(16'(so_oe), 16'h0000);
    cmd(2, 24'h00D060);
    chk(16'(detect_en), 16'h0040);
    cmd(2, 24'h00D0BF);
    chk(16'(detect_en), 16'h00BF);
    for (i = 0; i < 5; i++) begin
      @(posedge clk_sys) flt <= 5'(1 << i);
      rd_err(ssecd_pkg::OP_READ_ERR | 8'(i & 1), rd);
      chk(16'(rd), 16'(1 << fpos[i]));
      @(posedge clk_sys) flt <= 5'h00;
      repeat (6) @(posedge clk_sys);
      cmd(1, 24'h0000FF);
      chk(16'(fault), 16'h0000);
    end
    @(posedge clk_sys) flt <= 5'h01;
    repeat (6) @(posedge clk_sys);
    cmd(1, 24'h0000FF);
    chk(16'(fault), 16'h0004);
    @(posedge clk_sys) flt <= 5'h00;
    repeat (6) @(posedge clk_sys);
    cmd(1, 24'h0000FF);
    pulse(1'b1);
    chk(16'(fault), 16'h0020);
    pulse(1'b1);
    chk(16'(fault), 16'h0060);
    cmd(2, 24'h00D040);
    cmd(1, 24'h0000FF);
    chk(16'(fault), 16'h0000);
    pulse(1'b0);
    chk(16'(fault), 16'h0040);
    cmd(2, 24'h00D001);
    cmd(1, 24'h0000FF);
    cmd(2, 24'h00C4C0);
    chk(16'(fault), 16'h0001);
    chk(16'(n_preset), 16'h0000);
    // A routing byte with its top bit set is refused and leaves pin A alone
    cmd(1, 24'h0000FF);
    cmd(2, 24'h00C0A1);
    chk(16'(fault), 16'h0001);
    chk(16'(out_a), 16'h0000);
    @(posedge clk_sys) accept <= 4'hB;
    cmd(1, 24'h0000FF);
    cmd(3, 24'hC82FFF);
    chk(16'(n_play), 16'h0000);
    chk(16'(fault), 16'h0001);
    cmd(3, 24'hC81234);
    chk(16'(n_play), 16'h0001);
    chk(16'(cap), {2'h0, 2'h1, 12'h234});
    cmd(3, 24'hC43ABC);
    chk(16'(n_preset), 16'h0001);
    chk(16'(cap), {2'h0, 2'h3, 12'hABC});
    chk(16'(n_play), 16'h0001);
    for (i = 0; i < 4; i++) begin
      cmd(2, {8'h00, ssecd_pkg::OP_ROUTE, 2'b00, 2'(i), 4'h6});
      chk(16'(out_a), 16'(i == 1 ? 0 : 1));
    end
    cmd(2, 24'h00C053);
    chk(16'(out_b), 16'h0001);
    chk(16'(out_a), 16'h0001);
    cmd(1, 24'h0000FF);
    chk(16'(out_a), 16'h0000);
    final_report();
  end

  // Run needs about 20 us; this limit leaves ample margin
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
endmodule // ssecd_top_test

/* File: rtl/ssecd_link.sv */
// Serial link shifter on the link clock: byte receive and reply shift-out
`timescale 1ns/1ps
module ssecd_link (
  // Link clock and reset
  input  wire logic       sck,
  input  wire logic       rst_n,
  // Serial pins
  input  wire logic       si,
  output logic            so,
  output logic            so_oe,
  // System side, reply held stable by the system domain
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  // Received byte, stable until the next toggle
  output logic [7:0]      rx_byte,
  output logic            rx_toggle
);
  logic [2:0] cnt_ff;
  logic [6:0] sh_ff;
  logic [7:0] rx_byte_ff;
  logic       rx_tog_ff;

  // Byte framing by bit count, MSB first
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 3'h0;
      sh_ff  <= 7'h00;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
      sh_ff  <= {sh_ff[5:0], si};
    end
  end

  // Completed byte is held until eight more bits arrive, so it is stable when sampled
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte_ff <= 8'h00;
      rx_tog_ff  <= 1'b0;
    end else if (cnt_ff == ssecd_pkg::BIT_LAST) begin
      rx_byte_ff <= {sh_ff, si};
      rx_tog_ff  <= ~rx_tog_ff;
    end
  end

  // Reply bit chosen from the stable system-side byte; 7 - count is ~count
  assign so        = tx_valid & tx_byte[~cnt_ff];
  assign so_oe     = tx_valid;
  assign rx_byte   = rx_byte_ff;
  assign rx_toggle = rx_tog_ff;
endmodule // ssecd_link

/* File: rtl/ssecd_pkg.sv */
// Shared constants and types for the speech status and error command decoder
package ssecd_pkg;
  // Opcodes
  localparam logic [7:0] OP_ROM_INFO    = 8'hB4;
  localparam logic [7:0] OP_READ_ERR    = 8'hB8;
  localparam logic [7:0] OP_READ_MASK   = 8'hFE;
  localparam logic [7:0] OP_ROUTE       = 8'hC0;
  localparam logic [7:0] OP_PRESET      = 8'hC4;
  localparam logic [7:0] OP_PLAY        = 8'hC8;
  localparam logic [7:0] OP_SAFETY      = 8'hD0;
  localparam logic [7:0] OP_ERR_CLEAR   = 8'hFF;
  localparam logic [7:0] READ_FILL      = 8'h00;
  // Fault and enable bit positions
  localparam int FB_CLK_STOP = 7;
  localparam int FB_RECOVERY = 6;
  localparam int FB_WDT      = 5;
  localparam int FB_FLASH    = 4;
  localparam int FB_SHORT    = 3;
  localparam int FB_HEAT     = 2;
  localparam int FB_OPEN     = 1;
  localparam int FB_BADCMD   = 0;
  // Routing byte fields
  localparam int RT_ZERO_BIT = 7;
  localparam int RT_PIN_BIT  = 6;
  localparam int RT_SRC_HI   = 5;
  localparam int RT_SRC_LO   = 4;
  localparam int RT_MASK_HI  = 3;
  // Phrase byte fields
  localparam int PH_ZERO_HI  = 7;
  localparam int PH_ZERO_LO  = 6;
  localparam int PH_CH_HI    = 5;
  localparam int PH_CH_LO    = 4;
  localparam int PH_NUM_HI   = 3;
  // Status pin sources
  localparam logic [1:0] SRC_BUSY  = 2'h0;
  localparam logic [1:0] SRC_READY = 2'h1;
  // Reset values and the bit count that ends a byte
  localparam logic [3:0] MASK_RST   = 4'h1;
  localparam logic [7:0] DET_EN_RST = 8'h00;
  localparam logic [7:0] FAULT_RST  = 8'h00;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  // Decoder states
  typedef enum logic [1:0] {ST_OPCODE, ST_ARG1, ST_ARG2, ST_READ} ssecd_state_t;
endpackage

/* File: rtl/ssecd_top.sv */
// Command decoder for ROM info, error status, status routing, safety and phrase commands
`timescale 1ns/1ps
module ssecd_top #(
  parameter int CH_N = 4
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // Serial link
  input  wire logic        SCK,
  input  wire logic        SI,
  output logic             SO,
  output logic             SO_OE,
  // Channel state from playback logic
  input  wire logic [3:0]  CMD_ACCEPT_FLAG,
  input  wire logic [3:0]  CHANNEL_ACTIVE_N,
  // Detector pins, asynchronous levels
  input  wire logic        CLOCK_STOP_IN,
  input  wire logic        FLASH_ERR_IN,
  input  wire logic        OUTPUT_SHORT_IN,
  input  wire logic        OVERHEAT_IN,
  input  wire logic        SPEAKER_OPEN_IN,
  // Counter overflow pulses on CLK_SYS
  input  wire logic        WDT_OVERFLOW,
  input  wire logic        RECOVERY_OVERFLOW,
  // Sound ROM information
  input  wire logic [7:0]  ROM_INFO,
  // Detection enables and error status
  output logic [7:0]       DETECT_EN,
  output logic [7:0]       FAULT_STATUS,
  // Phrase requests
  output logic             PRESET_STB,
  output logic             PLAY_STB,
  output logic [1:0]       PHRASE_CHAN,
  output logic [11:0]      PHRASE_NUM,
  // Status pins
  output logic             STATE_OUT_A,
  output logic             STATE_OUT_B
);
  if (CH_N != 4) begin : g_bad_ch
    $error("ssecd_top: CH_N must be 4");
  end

  ssecd_pkg::ssecd_state_t state_ff;
  logic        rst_s1_ff, rst_n_ff;
  logic        tog_s1_ff, tog_s2_ff, tog_d_ff;
  logic [4:0]  pin_s1_ff, pin_s2_ff;
  logic [7:0]  rx_byte;
  logic        rx_toggle;
  logic        rx_evt;
  logic [7:0]  op_ff, arg1_ff;
  logic [7:0]  tx_byte_ff;
  logic        tx_valid_ff;
  logic [7:0]  det_en_ff, fault_ff;
  logic        wdt_seen_ff;
  logic [1:0]  src_a_ff, src_b_ff;
  logic [3:0]  mask_a_ff, mask_b_ff;
  logic        out_a_ff, out_b_ff;
  logic        preset_ff, play_ff;
  logic [1:0]  chan_ff;
  logic [11:0] num_ff;
  logic [7:0]  cond, set_vec;
  logic [1:0]  arg_ch;
  // Decoder events
  ssecd_pkg::ssecd_state_t nxt_state;
  logic        ev_route, ev_safe, ev_preset, ev_play, ev_clear, ev_bad, ev_reply;
  logic        ev_read_done;
  logic [7:0]  nxt_reply;

  function automatic logic route_level(input logic [1:0] src, input logic [3:0] msk,
                                       input logic [3:0] busy_n, input logic [3:0] rdy,
                                       input logic err);
    case (src)
      ssecd_pkg::SRC_BUSY:  route_level = &(busy_n | ~msk);
      ssecd_pkg::SRC_READY: route_level = &(rdy | ~msk);
      default:              route_level = err;
    endcase
  endfunction
  // Reset release through two flops
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end
  ssecd_link ssecd_link_inst (
    .sck       (SCK),
    .rst_n     (rst_n_ff),
    .si        (SI),
    .so        (SO),
    .so_oe     (SO_OE),
    .tx_byte   (tx_byte_ff),
    .tx_valid  (tx_valid_ff),
    .rx_byte   (rx_byte),
    .rx_toggle (rx_toggle)
  );
  // Byte-done toggle and detector pins cross through two flops
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tog_s1_ff <= 1'b0;
      tog_s2_ff <= 1'b0;
      tog_d_ff  <= 1'b0;
      pin_s1_ff <= 5'h00;
      pin_s2_ff <= 5'h00;
    end else begin
      tog_s1_ff <= rx_toggle;
      tog_s2_ff <= tog_s1_ff;
      tog_d_ff  <= tog_s2_ff;
      pin_s1_ff <= {CLOCK_STOP_IN, FLASH_ERR_IN, OUTPUT_SHORT_IN, OVERHEAT_IN, SPEAKER_OPEN_IN};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  // Received byte stays stable for eight link clocks after the toggle
  assign rx_evt = tog_s2_ff ^ tog_d_ff;
  assign arg_ch = arg1_ff[ssecd_pkg::PH_CH_HI:ssecd_pkg::PH_CH_LO];

  always_comb begin
    nxt_state    = state_ff;
    ev_route     = 1'b0;
    ev_safe      = 1'b0;
    ev_preset    = 1'b0;
    ev_play      = 1'b0;
    ev_clear     = 1'b0;
    ev_bad       = 1'b0;
    ev_reply     = 1'b0;
    ev_read_done = 1'b0;
    nxt_reply    = tx_byte_ff;
    if (rx_evt) begin
      case (state_ff)
        ssecd_pkg::ST_OPCODE: begin
          // No ready-flag check on this path
          if (rx_byte == ssecd_pkg::OP_ROM_INFO) begin
            ev_reply  = 1'b1;
            nxt_reply = ROM_INFO;
            nxt_state = ssecd_pkg::ST_READ;
          end else if ((rx_byte & ssecd_pkg::OP_READ_MASK) == ssecd_pkg::OP_READ_ERR) begin
            ev_reply  = 1'b1;
            nxt_reply = fault_ff;
            nxt_state = ssecd_pkg::ST_READ;
          end else if (rx_byte == ssecd_pkg::OP_ROUTE || rx_byte == ssecd_pkg::OP_SAFETY ||
                       rx_byte == ssecd_pkg::OP_PRESET || rx_byte == ssecd_pkg::OP_PLAY) begin
            nxt_state = ssecd_pkg::ST_ARG1;
          end else if (rx_byte == ssecd_pkg::OP_ERR_CLEAR) begin
            ev_clear = 1'b1;
          end
        end
        ssecd_pkg::ST_ARG1: begin
          nxt_state = ssecd_pkg::ST_OPCODE;
          if (op_ff == ssecd_pkg::OP_ROUTE) begin
            ev_route = !rx_byte[ssecd_pkg::RT_ZERO_BIT];
            ev_bad   = rx_byte[ssecd_pkg::RT_ZERO_BIT];
          end else if (op_ff == ssecd_pkg::OP_SAFETY) begin
            ev_safe = 1'b1;
          end else if (rx_byte[ssecd_pkg::PH_ZERO_HI] || rx_byte[ssecd_pkg::PH_ZERO_LO]) begin
            ev_bad = 1'b1;
          end else begin
            nxt_state = ssecd_pkg::ST_ARG2;
          end
        end
        ssecd_pkg::ST_ARG2: begin
          nxt_state = ssecd_pkg::ST_OPCODE;
          // A phrase command for a channel that is not ready is refused
          if (!CMD_ACCEPT_FLAG[arg_ch]) begin
            ev_bad = 1'b1;
          end else if (op_ff == ssecd_pkg::OP_PLAY) begin
            ev_play = 1'b1;
          end else begin
            ev_preset = 1'b1;
          end
        end
        ssecd_pkg::ST_READ: begin
          nxt_state    = ssecd_pkg::ST_OPCODE;
          ev_read_done = 1'b1;
          ev_bad       = rx_byte != ssecd_pkg::READ_FILL;
        end
        default: nxt_state = ssecd_pkg::ST_OPCODE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ssecd_pkg::ST_OPCODE;
      op_ff    <= 8'h00;
      arg1_ff  <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (rx_evt && state_ff == ssecd_pkg::ST_OPCODE) begin
        op_ff <= rx_byte;
      end
      if (rx_evt && state_ff == ssecd_pkg::ST_ARG1) begin
        arg1_ff <= rx_byte;
      end
    end
  end
  // Reply held stable until the host has clocked the read byte
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tx_byte_ff  <= 8'h00;
      tx_valid_ff <= 1'b0;
    end else begin
      tx_byte_ff <= nxt_reply;
      if (ev_reply) begin
        tx_valid_ff <= 1'b1;
      end else if (ev_read_done) begin
        tx_valid_ff <= 1'b0;
      end
    end
  end
  // Detection enables
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      det_en_ff <= ssecd_pkg::DET_EN_RST;
    end else if (ev_safe) begin
      det_en_ff <= rx_byte;
      if (rx_byte[ssecd_pkg::FB_WDT] && rx_byte[ssecd_pkg::FB_RECOVERY]) begin
        det_en_ff[ssecd_pkg::FB_WDT] <= 1'b0;
      end
    end
  end
  // Present conditions; watchdog, recovery and command faults are events only
  always_comb begin
    cond                        = 8'h00;
    cond[ssecd_pkg::FB_CLK_STOP] = pin_s2_ff[4];
    cond[ssecd_pkg::FB_FLASH]   = pin_s2_ff[3];
    cond[ssecd_pkg::FB_SHORT]   = pin_s2_ff[2];
    cond[ssecd_pkg::FB_HEAT]    = pin_s2_ff[1];
    cond[ssecd_pkg::FB_OPEN]    = pin_s2_ff[0];
    set_vec = det_en_ff & cond;
    set_vec[ssecd_pkg::FB_WDT] = det_en_ff[ssecd_pkg::FB_WDT] & WDT_OVERFLOW & !wdt_seen_ff;
    set_vec[ssecd_pkg::FB_RECOVERY] = (det_en_ff[ssecd_pkg::FB_WDT] & WDT_OVERFLOW & wdt_seen_ff)
                                    | (det_en_ff[ssecd_pkg::FB_RECOVERY] & RECOVERY_OVERFLOW);
    set_vec[ssecd_pkg::FB_BADCMD] = det_en_ff[ssecd_pkg::FB_BADCMD] & ev_bad;
  end
  // Sticky faults; a set in the clear cycle wins, so a lasting condition survives the clear
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      fault_ff    <= ssecd_pkg::FAULT_RST;
      wdt_seen_ff <= 1'b0;
    end else begin
      fault_ff <= (ev_clear ? ssecd_pkg::FAULT_RST : fault_ff) | set_vec;
      if (set_vec[ssecd_pkg::FB_WDT]) begin
        wdt_seen_ff <= 1'b1;
      end
    end
  end
  // Status pin routing, one set of fields per pin
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      src_a_ff  <= ssecd_pkg::SRC_READY;
      mask_a_ff <= ssecd_pkg::MASK_RST;
      src_b_ff  <= ssecd_pkg::SRC_BUSY;
      mask_b_ff <= ssecd_pkg::MASK_RST;
    end else if (ev_route) begin
      if (rx_byte[ssecd_pkg::RT_PIN_BIT]) begin
        src_b_ff  <= rx_byte[ssecd_pkg::RT_SRC_HI:ssecd_pkg::RT_SRC_LO];
        mask_b_ff <= rx_byte[ssecd_pkg::RT_MASK_HI:0];
      end else begin
        src_a_ff  <= rx_byte[ssecd_pkg::RT_SRC_HI:ssecd_pkg::RT_SRC_LO];
        mask_a_ff <= rx_byte[ssecd_pkg::RT_MASK_HI:0];
      end
    end
  end
  // Selected channels are ANDed: the pin drops when any selected flag is low
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      out_a_ff <= 1'b0;
      out_b_ff <= 1'b0;
    end else begin
      out_a_ff <= route_level(src_a_ff, mask_a_ff, CHANNEL_ACTIVE_N, CMD_ACCEPT_FLAG,
                              |fault_ff);
      out_b_ff <= route_level(src_b_ff, mask_b_ff, CHANNEL_ACTIVE_N, CMD_ACCEPT_FLAG,
                              |fault_ff);
    end
  end
  // Preset only loads the phrase; the playback logic waits for its start command
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      preset_ff <= 1'b0;
      play_ff   <= 1'b0;
      chan_ff   <= 2'h0;
      num_ff    <= 12'h000;
    end else begin
      preset_ff <= ev_preset;
      play_ff   <= ev_play;
      if (ev_preset || ev_play) begin
        chan_ff <= arg_ch;
        num_ff  <= {arg1_ff[ssecd_pkg::PH_NUM_HI:0], rx_byte};
      end
    end
  end
  assign DETECT_EN    = det_en_ff;
  assign FAULT_STATUS = fault_ff;
  assign PRESET_STB   = preset_ff;
  assign PLAY_STB     = play_ff;
  assign PHRASE_CHAN  = chan_ff;
  assign PHRASE_NUM   = num_ff;
  assign STATE_OUT_A  = out_a_ff;
  assign STATE_OUT_B  = out_b_ff;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n_ff);

  sequence s_play_arg;
    rx_evt && state_ff == ssecd_pkg::ST_ARG2 && op_ff == ssecd_pkg::OP_PLAY;
  endsequence

  a_rom_reply: assert property (rx_evt && state_ff == ssecd_pkg::ST_OPCODE
      && rx_byte == ssecd_pkg::OP_ROM_INFO |=> tx_valid_ff && tx_byte_ff == $past(ROM_INFO))
    else $error("ROM info reply wrong");
  a_err_reply: assert property (rx_evt && state_ff == ssecd_pkg::ST_OPCODE
      && (rx_byte & ssecd_pkg::OP_READ_MASK) == ssecd_pkg::OP_READ_ERR
      |=> tx_valid_ff && tx_byte_ff == $past(fault_ff))
    else $error("Error read reply wrong");
  a_bad_cmd_set: assert property (ev_bad && det_en_ff[ssecd_pkg::FB_BADCMD]
      |=> fault_ff[ssecd_pkg::FB_BADCMD])
    else $error("Command error bit not set");
  a_heat_latch: assert property (det_en_ff[ssecd_pkg::FB_HEAT] && pin_s2_ff[1]
      |=> fault_ff[ssecd_pkg::FB_HEAT])
    else $error("Overheat not latched");
  a_route_keep: assert property (ev_route && rx_byte[ssecd_pkg::RT_PIN_BIT]
      |=> $stable(src_a_ff) && $stable(mask_a_ff))
    else $error("Pin A routing disturbed");
  a_play_launch: assert property (s_play_arg and (CMD_ACCEPT_FLAG[arg_ch])
      |=> play_ff && num_ff == {$past(arg1_ff[3:0]), $past(rx_byte)} ##1 !play_ff)
    else $error("Play request wrong");
  a_preset_gate: assert property (preset_ff |-> $past(CMD_ACCEPT_FLAG)
      == ($past(CMD_ACCEPT_FLAG) | (4'h1 << chan_ff)))
    else $error("Preset on channel not ready");
  a_enable_excl: assert property (ev_safe |=> !(det_en_ff[ssecd_pkg::FB_WDT]
      && det_en_ff[ssecd_pkg::FB_RECOVERY]) && det_en_ff[7:6] == $past(rx_byte[7:6]))
    else $error("Enable exclusion broken");
  a_clear_keep: assert property (ev_clear |=> fault_ff == $past(set_vec))
    else $error("Clear result wrong");
  a_wdt_first: assert property (!wdt_seen_ff && WDT_OVERFLOW
      && det_en_ff[ssecd_pkg::FB_WDT] |=> fault_ff[ssecd_pkg::FB_WDT] && wdt_seen_ff)
    else $error("First watchdog overflow missed");
endmodule // ssecd_top
